// >>> logic/ccrs_pkg.sv
// shared constants and types for the core clock and reset sequencer
`default_nettype none

package ccrs_pkg;

   // register byte offsets on the apb port
   localparam logic [3:0] PWR_CTL_OFS    = 4'h0;
   localparam logic [3:0] STATUS_OFS     = 4'h4;

   // power_mgmt_control field layout and reset values
   localparam int         MULT_LSB       = 0;
   localparam int         MULT_W         = 6;
   localparam int         DIV_LSB        = 6;
   localparam int         DIV_W          = 2;
   localparam int         OUT_SEL_BIT    = 12;
   localparam logic [1:0] DIV_RST        = 2'h0;
   localparam logic       OUT_SEL_RST    = 1'b0;

   // status field layout
   localparam int         ST_RUN_BIT     = 0;
   localparam int         ST_PLL_BIT     = 1;
   localparam int         ST_STRAP_LSB   = 2;
   localparam int         ST_TAP_LSB     = 4;

   // ratio_select_pins encodings and the multipliers they start with
   localparam logic [1:0] RATIO_3        = 2'h0;
   localparam logic [1:0] RATIO_16       = 2'h1;
   localparam logic [1:0] RATIO_8        = 2'h2;
   localparam logic [1:0] RATIO_RSVD     = 2'h3;
   localparam logic [5:0] MULT_3         = 6'h03;
   localparam logic [5:0] MULT_16        = 6'h10;
   localparam logic [5:0] MULT_8         = 6'h08;
   localparam logic [5:0] MULT_DIRECT    = 6'h01;

   // pll lock wait, in input_clock_pin cycles
   localparam int         LOCK_CYCLES    = 4096;
   localparam int         SINCE_W        = 13;

   // test access port
   localparam int         IR_W           = 2;
   localparam int         BSR_LEN        = 8;
   localparam logic [1:0] IR_BYPASS      = 2'h3;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
      TAP_PA_DR, TAP_EX2_DR, TAP_UP_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
      TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UP_IR
   } ccrs_tap_t;

endpackage : ccrs_pkg

`default_nettype wire

// >>> logic/ccrs_lock_timer.sv
// pll lock wait counter, done rises on the n-th edge after release
`timescale 1ns/1ps
`default_nettype none

module ccrs_lock_timer #(
   parameter int N = 4096
) (
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic reset_n_i,
   // status
   output logic      done_o
);
   import ccrs_pkg::*;

   logic [SINCE_W-1:0] cnt;

   // count stops once done, so a long run cannot wrap it
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         cnt    <= '0;
         done_o <= 1'b0;
      end else if (!done_o) begin
         cnt    <= cnt + 1'b1;
         done_o <= (cnt == SINCE_W'(N - 1));
      end
   end

endmodule : ccrs_lock_timer

`default_nettype wire

// >>> logic/ccrs_tap.sv
// boundary-scan test access port, tck sampled on the system clock
`timescale 1ns/1ps
`default_nettype none

module ccrs_tap #(
   parameter int LEN = 8
) (
   // clock and reset
   input  wire logic           ref_clk_i,
   input  wire logic           reset_n_i,
   // test pins
   input  wire logic           trst_n_i,
   input  wire logic           tck_i,
   input  wire logic           tms_i,
   input  wire logic           tdi_i,
   output logic                tdo_o,
   output logic                tdo_oe_o,
   // scan path contents
   input  wire logic [LEN-1:0] capture_i,
   output ccrs_pkg::ccrs_tap_t state_o
);
   import ccrs_pkg::*;

   ccrs_tap_t       next_state;
   logic            tck_q;
   logic            tck_rise;
   logic            tck_fall;
   logic [LEN-1:0]  bsr;
   logic [IR_W-1:0] ir;
   logic [IR_W-1:0] ir_sh;
   logic            byp;

   // tck is a plain synchronous input, edges found by one delay
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) tck_q <= 1'b0;
      else tck_q <= tck_i;
   end
   assign tck_rise = tck_i & ~tck_q;
   assign tck_fall = ~tck_i & tck_q;

   // standard sixteen-state controller steered by tms
   always_comb begin
      next_state = state_o;
      unique case (state_o)
         TAP_RESET:  next_state = tms_i ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   next_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: next_state = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: next_state = tms_i ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  next_state = tms_i ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: next_state = tms_i ? TAP_UP_DR  : TAP_PA_DR;
         TAP_PA_DR:  next_state = tms_i ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: next_state = tms_i ? TAP_UP_DR  : TAP_SH_DR;
         TAP_UP_DR:  next_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: next_state = tms_i ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: next_state = tms_i ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  next_state = tms_i ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: next_state = tms_i ? TAP_UP_IR  : TAP_PA_IR;
         TAP_PA_IR:  next_state = tms_i ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: next_state = tms_i ? TAP_UP_IR  : TAP_SH_IR;
         TAP_UP_IR:  next_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
      endcase
   end

   // test reset wins over any tck edge in the same cycle
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || !trst_n_i) state_o <= TAP_RESET;
      else if (tck_rise) state_o <= next_state;
   end

   // scan and instruction shifting on the rising tck edge
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || !trst_n_i || state_o == TAP_RESET) begin
         bsr   <= '0;
         ir    <= IR_BYPASS;
         ir_sh <= '0;
         byp   <= 1'b0;
      end else if (tck_rise) begin
         unique case (state_o)
            TAP_CAP_DR: begin
               bsr <= capture_i;
               byp <= 1'b0;
            end
            TAP_SH_DR: begin
               bsr <= {tdi_i, bsr[LEN-1:1]};
               byp <= tdi_i;
            end
            TAP_CAP_IR: ir_sh <= IR_W'(1);
            TAP_SH_IR:  ir_sh <= {tdi_i, ir_sh[IR_W-1:1]};
            TAP_UP_IR:  ir    <= ir_sh;
            default: ;
         endcase
      end
   end

   // tdo changes on the falling edge, driven only while shifting
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || !trst_n_i) begin
         tdo_o    <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe_o <= (state_o == TAP_SH_DR) || (state_o == TAP_SH_IR);
         if (state_o == TAP_SH_IR) tdo_o <= ir_sh[0];
         else tdo_o <= (ir == IR_BYPASS) ? byp : bsr[0];
      end
   end

   property p_trst_resets;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      !trst_n_i |=> (state_o == TAP_RESET) && !tdo_oe_o;
   endproperty
   a_trst_resets: assert property (p_trst_resets)
      else $error("test reset did not return the controller to reset");

endmodule : ccrs_tap

`default_nettype wire

// >>> logic/ccrs_top.sv
// core clock source, ratio, reset sequencing and shared output pin
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - core clock from pll or input clock
// - ratio pins set start-up core frequency
// - codes 00=3:1, 01=16:1, 10=8:1, 11 reserved
// - software retunes multiplier/divider after reset
// - bit 12 picks clock or reset-out
// - reset-out mirrors core reset state outward
// - core starts 4096 clocks after release
// - tap driven by tms, tdi in, tdo out
module ccrs_top #(
   parameter int ADDR_W      = 12,
   parameter int LOCK_CYCLES = ccrs_pkg::LOCK_CYCLES
) (
   // clock and reset
   input  wire logic                        ref_clk_i,
   input  wire logic                        reset_n_i,
   // board straps
   input  wire logic [1:0]                  ratio_select_pins_i,
   // apb slave
   input  wire logic                        psel_i,
   input  wire logic                        penable_i,
   input  wire logic                        pwrite_i,
   input  wire logic [ADDR_W-1:0]           paddr_i,
   input  wire logic [31:0]                 pwdata_i,
   input  wire logic [3:0]                  pstrb_i,
   output logic                             pready_o,
   output logic [31:0]                      prdata_o,
   output logic                             pslverr_o,
   // core clocking and reset
   output logic                             core_clk_pll_o,
   output logic [ccrs_pkg::MULT_W-1:0]      core_mult_o,
   output logic [ccrs_pkg::DIV_W-1:0]       core_div_o,
   output logic                             core_rst_n_o,
   // shared reset-out / clock-out pin
   output logic                             shared_out_pin_o,
   // test port
   input  wire logic                        trst_n_i,
   input  wire logic                        tck_i,
   input  wire logic                        tms_i,
   input  wire logic                        tdi_i,
   output logic                             tdo_o,
   output logic                             tdo_oe_o
);
   import ccrs_pkg::*;

   logic [1:0]         strap;
   logic               lock_done;
   logic               run;
   logic               clk_out_sel;
   logic [DIV_W-1:0]   clk_cnt;
   logic               clk_tog;
   logic               acc;
   logic               fin;
   logic               hit_pm;
   logic               hit_st;
   logic               wr_ok;
   logic [31:0]        pm_word;
   logic [31:0]        st_word;
   logic [SINCE_W-1:0] since;
   ccrs_tap_t          tap_state;

   // start-up multiplier for each strap code
   function automatic logic [MULT_W-1:0] ratio_mult(input logic [1:0] code);
      unique case (code)
         RATIO_3:  ratio_mult = MULT_3;
         RATIO_16: ratio_mult = MULT_16;
         RATIO_8:  ratio_mult = MULT_8;
         default:  ratio_mult = MULT_DIRECT;
      endcase
   endfunction : ratio_mult

   // straps are followed while reset is low and frozen at release;
   // the board keeps reset low through power-up so they settle first
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) strap <= ratio_select_pins_i;
   end

   // pll lock wait; relies on the input clock never pausing
   ccrs_lock_timer #(
      .N         (LOCK_CYCLES - 1)
   ) u_lock (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .done_o    (lock_done)
   );

   // core leaves reset one edge after lock, exactly LOCK_CYCLES in
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) run <= 1'b0;
      else run <= lock_done;
   end

   // core reset registered from lock_done like run, low through the lock wait
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) core_rst_n_o <= 1'b0;
      else core_rst_n_o <= lock_done;
   end

   // reserved strap code falls back to the raw input clock
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) core_clk_pll_o <= 1'b0;
      else core_clk_pll_o <= (strap != RATIO_RSVD);
   end

   // apb decode, one wait state so every answer comes from a flop
   assign acc    = psel_i & penable_i;
   assign fin    = acc & pready_o;
   assign hit_pm = (paddr_i == ADDR_W'(PWR_CTL_OFS));
   assign hit_st = (paddr_i == ADDR_W'(STATUS_OFS));
   // frequency writes are refused until the core is out of reset
   assign wr_ok  = fin & pwrite_i & hit_pm & run;

   // read views of both registers, unused bits read zero
   always_comb begin
      pm_word = '0;
      pm_word[MULT_LSB +: MULT_W] = core_mult_o;
      pm_word[DIV_LSB +: DIV_W]   = core_div_o;
      pm_word[OUT_SEL_BIT]        = clk_out_sel;
      st_word = '0;
      st_word[ST_RUN_BIT]         = run;
      st_word[ST_PLL_BIT]         = core_clk_pll_o;
      st_word[ST_STRAP_LSB +: 2]  = strap;
      st_word[ST_TAP_LSB +: 4]    = tap_state;
   end

   // pready rises in the second access cycle and drops after it
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) pready_o <= 1'b0;
      else pready_o <= acc & ~pready_o;
   end

   // error on unmapped address or an early frequency write
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) pslverr_o <= 1'b0;
      else pslverr_o <= acc & ~pready_o &
                        (~(hit_pm | hit_st) | (pwrite_i & hit_pm & ~run));
   end

   // read data captured with pready, zero otherwise
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) prdata_o <= '0;
      else if (acc & ~pready_o & ~pwrite_i & hit_pm) prdata_o <= pm_word;
      else if (acc & ~pready_o & ~pwrite_i & hit_st) prdata_o <= st_word;
      else prdata_o <= '0;
   end

   // multiplier tracks the straps until the core runs, then software
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || !run) begin
         core_mult_o <= ratio_mult(strap);
      end else if (wr_ok && pstrb_i[0]) begin
         core_mult_o <= pwdata_i[MULT_LSB +: MULT_W];
      end
   end

   // divider code, written in the same byte lane
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) core_div_o <= DIV_RST;
      else if (wr_ok && pstrb_i[0]) core_div_o <= pwdata_i[DIV_LSB +: DIV_W];
   end

   // output pin function select, byte lane one
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) clk_out_sel <= OUT_SEL_RST;
      else if (wr_ok && pstrb_i[1]) clk_out_sel <= pwdata_i[OUT_SEL_BIT];
   end

   // stand-in for the pll output: the real pll is analog and lives
   // outside this logic, so only a divided copy of the ref is made
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         clk_cnt <= '0;
         clk_tog <= 1'b0;
      end else if (clk_cnt >= core_div_o) begin
         clk_cnt <= '0;
         clk_tog <= ~clk_tog;
      end else begin
         clk_cnt <= clk_cnt + 1'b1;
      end
   end

   // shared pin: reset-out by default, low while the core is held;
   // fed from lock_done so it rises on the same edge as core reset
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) shared_out_pin_o <= 1'b0;
      else if (clk_out_sel) shared_out_pin_o <= clk_tog;
      else shared_out_pin_o <= lock_done;
   end

   // boundary scan sees the clocking state of the block
   ccrs_tap #(
      .LEN       (BSR_LEN)
   ) u_tap (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .trst_n_i  (trst_n_i),
      .tck_i     (tck_i),
      .tms_i     (tms_i),
      .tdi_i     (tdi_i),
      .tdo_o     (tdo_o),
      .tdo_oe_o  (tdo_oe_o),
      .capture_i ({clk_out_sel, core_div_o, strap, core_clk_pll_o, run,
                   core_rst_n_o}),
      .state_o   (tap_state)
   );

   // checking helper: edges since reset release, saturating
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) since <= '0;
      else if (since != '1) since <= since + 1'b1;
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   property p_run_wait;
      $rose(run) |-> since == SINCE_W'(LOCK_CYCLES);
   endproperty
   a_run_wait: assert property (p_run_wait)
      else $error("core started at the wrong edge after release");

   property p_rst_out_low;
      (since < SINCE_W'(LOCK_CYCLES)) && !clk_out_sel |->
         !shared_out_pin_o && !core_rst_n_o;
   endproperty
   a_rst_out_low: assert property (p_rst_out_low)
      else $error("reset-out released before the lock wait ended");

   property p_rst_out_follow;
      !clk_out_sel |=> shared_out_pin_o == core_rst_n_o;
   endproperty
   a_rst_out_follow: assert property (p_rst_out_follow)
      else $error("shared pin does not follow the core reset state");

   property p_clk_out_follow;
      clk_out_sel |=> shared_out_pin_o == $past(clk_tog);
   endproperty
   a_clk_out_follow: assert property (p_clk_out_follow)
      else $error("shared pin does not carry the clock when selected");

   // first edge after release still shows reset values, so skip it
   property p_strap_frozen;
      since != '0 |-> $stable(strap);
   endproperty
   a_strap_frozen: assert property (p_strap_frozen)
      else $error("strap sample changed after reset release");

   property p_src_sel;
      since != '0 |-> core_clk_pll_o == (strap != RATIO_RSVD);
   endproperty
   a_src_sel: assert property (p_src_sel)
      else $error("clock source does not match the ratio pins");

   property p_start_mult;
      $rose(run) |-> core_mult_o == ratio_mult(strap);
   endproperty
   a_start_mult: assert property (p_start_mult)
      else $error("start-up multiplier does not match the ratio code");

   property p_no_early_run;
      since < SINCE_W'(LOCK_CYCLES) |-> !run;
   endproperty
   a_no_early_run: assert property (p_no_early_run)
      else $error("core started inside the lock wait");

   property p_sel_default;
      !run |-> !clk_out_sel;
   endproperty
   a_sel_default: assert property (p_sel_default)
      else $error("shared pin left reset-out before the core started");

   property p_pll_mult;
      core_clk_pll_o && !run |-> core_mult_o != MULT_DIRECT;
   endproperty
   a_pll_mult: assert property (p_pll_mult)
      else $error("pll start-up multiplier is not a ratio code");

   property p_early_wr;
      fin && pwrite_i && hit_pm && !run |->
         pslverr_o ##1 $stable(core_div_o) && $stable(clk_out_sel);
   endproperty
   a_early_wr: assert property (p_early_wr)
      else $error("write before core start was not refused");

   property p_late_wr;
      fin && pwrite_i && hit_pm && run && pstrb_i[0] |=>
         core_mult_o == $past(pwdata_i[MULT_LSB +: MULT_W]);
   endproperty
   a_late_wr: assert property (p_late_wr)
      else $error("multiplier write after core start was lost");

   c_start: cover property ($rose(run));
   c_retune: cover property (wr_ok && pstrb_i[0]);
   c_clk_out: cover property ($rose(clk_out_sel));
   c_direct: cover property (run && !core_clk_pll_o);
   c_unmapped: cover property (fin && pslverr_o && !hit_pm);

endmodule : ccrs_top

`default_nettype wire

// >>> verif/ccrs_board_model.sv
// board side: reset supervisor and test controller
`timescale 1ns/1ps
`default_nettype none

module ccrs_board_model (
   // board clock
   input  wire logic clk_i,
   // reset supervisor
   output logic      reset_n_o,
   // test controller
   output logic      trst_n_o,
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o
);

   // power-up: both resets low, test clock parked, pulled lines high
   initial begin
      reset_n_o = 1'b0;
      trst_n_o  = 1'b0;
      tck_o     = 1'b0;
      tms_o     = 1'b1;
      tdi_o     = 1'b1;
   end

   // hold core reset for n edges, release just after an edge
   task automatic hold_reset(input int n);
      reset_n_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      reset_n_o <= 1'b1;
   endtask : hold_reset

   // single low pulse on test reset
   task automatic trst_pulse;
      trst_n_o <= 1'b0;
      repeat (2) @(posedge clk_i);
      trst_n_o <= 1'b1;
      @(posedge clk_i);
   endtask : trst_pulse

   // one test clock period; slow phases since tck is oversampled
   task automatic tap_tick(input logic ms, input logic di);
      tms_o <= ms;
      tdi_o <= di;
      @(posedge clk_i);
      tck_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      tck_o <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : tap_tick

endmodule : ccrs_board_model

`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the core clock and reset sequencer
`timescale 1ns/1ps
`default_nettype none

module tb;
   import ccrs_pkg::*;

   localparam int         LOCK  = 16;
   localparam int         LIMIT = 3000;
   // scan capture: sel 0, div 1, strap 2, pll 1, run 1, core out of reset
   localparam logic [7:0] CAPT  = 8'h37;
   localparam logic [11:0] PM   = 12'(PWR_CTL_OFS);
   localparam logic [11:0] ST   = 12'(STATUS_OFS);

   // stimulus and observed signals
   logic        ref_clk;
   logic [1:0]  straps;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        core_clk_pll;
   logic [5:0]  core_mult;
   logic [1:0]  core_div;
   logic        core_rst_n;
   logic        shared_pin;
   logic        tdo;
   logic        tdo_oe;
   logic        reset_n;
   logic        trst_n;
   logic        tck;
   logic        tms;
   logic        tdi;
   int          failures = 0;
   int          total_checks = 0;
   int          cyc = 0;

   ccrs_board_model u_board (
      .clk_i(ref_clk), .reset_n_o(reset_n), .trst_n_o(trst_n),
      .tck_o(tck), .tms_o(tms), .tdi_o(tdi)
   );

   ccrs_top #(.ADDR_W(12), .LOCK_CYCLES(LOCK)) u_dut (
      .ref_clk_i(ref_clk), .reset_n_i(reset_n),
      .ratio_select_pins_i(straps), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pstrb_i(4'hf), .pready_o(pready), .prdata_o(prdata),
      .pslverr_o(pslverr), .core_clk_pll_o(core_clk_pll),
      .core_mult_o(core_mult), .core_div_o(core_div),
      .core_rst_n_o(core_rst_n), .shared_out_pin_o(shared_pin),
      .trst_n_i(trst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .tdo_o(tdo), .tdo_oe_o(tdo_oe)
   );

   // free-running, never halted input clock
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // cycle count doubles as the hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         failures++;
         $display("[ERR] %0t run timed out", $time);
         tally_and_finish();
      end
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   // one apb transfer; request held until pready seen at an edge
   task automatic apb_xfer(input logic wr, input logic [11:0] a,
                           input logic [31:0] wd, output logic [31:0] rd,
                           output logic err);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      // no local limit: only the bench timeout ends a hung wait
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb_xfer

   // start multiplier per strap code, reserved code runs raw
   function automatic logic [5:0] exp_mult(input logic [1:0] s);
      case (s)
         2'h0:    return 6'h03;
         2'h1:    return 6'h10;
         2'h2:    return 6'h08;
         default: return 6'h01;
      endcase
   endfunction : exp_mult

   initial begin
      logic [1:0]  order [4];
      logic [1:0]  seq [12];
      logic [31:0] rd;
      logic        err;
      logic        b;
      int          r;
      int          ch;
      order = '{2'h0, 2'h1, 2'h3, 2'h2};
      // {tms,tdi}: idle, load ir 00, then enter data shift
      seq = '{2'b01, 2'b11, 2'b11, 2'b01, 2'b01, 2'b00,
              2'b10, 2'b11, 2'b01, 2'b11, 2'b01, 2'b01};
      straps = 2'h0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      // every strap code, each a fresh reset in mid-run
      foreach (order[i]) begin
         straps <= order[i];
         u_board.hold_reset(5);
         r = cyc;
         chk(32'(core_mult), 32'(exp_mult(order[i])), "mult");
         chk(32'(shared_pin), 32'h0, "rst out");
         apb_xfer(1'b1, PM, 32'h0000_10c5, rd, err);
         chk(32'(err), 32'h1, "early write");
         while (core_rst_n !== 1'b1 && cyc - r < 200) begin
            @(posedge ref_clk);
            chk(32'(shared_pin), 32'(core_rst_n), "rst out");
         end
         chk(32'(cyc - r), 32'(LOCK + 1), "lock wait");
         chk(32'(core_clk_pll), 32'(order[i] != 2'h3), "src");
         apb_xfer(1'b0, ST, 32'h0, rd, err);
         chk(32'(rd[3:0]), 32'({order[i], order[i] != 2'h3, 1'b1}),
             "status");
         apb_xfer(1'b0, PM, 32'h0, rd, err);
         chk(rd, 32'(exp_mult(order[i])), "pwr ctl");
      end
      // retune once running: mult 0x0a, div 1
      apb_xfer(1'b1, PM, 32'h0000_004a, rd, err);
      repeat (2) @(posedge ref_clk);
      chk(32'({err, core_div, core_mult}), 32'h04a, "retune");
      // clock-out toggles every div+1 cycles: 4 changes in 8
      apb_xfer(1'b1, PM, 32'h0000_104a, rd, err);
      repeat (3) @(posedge ref_clk);
      ch = 0;
      for (int k = 0; k < 8; k++) begin
         b = shared_pin;
         @(posedge ref_clk);
         if (shared_pin !== b) ch++;
      end
      chk(32'(ch), 32'h4, "clock out");
      apb_xfer(1'b1, PM, 32'h0000_004a, rd, err);
      repeat (3) @(posedge ref_clk);
      chk(32'(shared_pin), 32'h1, "rst out back");
      // read-only and unmapped places
      apb_xfer(1'b1, ST, 32'hffff_ffff, rd, err);
      chk(32'(err), 32'h0, "status write");
      apb_xfer(1'b0, 12'h008, 32'h0, rd, err);
      chk({rd[31:1], err}, 32'h1, "unmapped");
      apb_xfer(1'b0, PM, 32'h0, rd, err);
      chk(rd, 32'h0000_004a, "pwr ctl kept");
      // test port: reset, then read the captured scan path
      u_board.trst_pulse();
      chk(32'(tdo_oe), 32'h0, "tdo idle");
      foreach (seq[j]) u_board.tap_tick(seq[j][1], seq[j][0]);
      for (int k = 0; k < 8; k++) begin
         chk(32'({tdo_oe, tdo}), 32'({1'b1, CAPT[k]}), "scan");
         u_board.tap_tick(k == 7, 1'b0);
      end
      tally_and_finish();
   end

endmodule : tb

`default_nettype wire
